// [hdl/frame_bit_edge.sv]
/*
  Samples one bit of each received cyclic word and flags a rising edge
  against the previous word. Assumes the word and its strobe share mclk.
*/
`timescale 1ns/1ns
module frame_bit_edge (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic frame_strobe,
  input  wire logic bit_in,
  output logic      level,
  output logic      rise
);

  // previous frame's value of the bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      level <= 1'b0;
    end else if (frame_strobe) begin
      level <= bit_in;
    end
  end

  // edge only counts in the frame that carries it
  assign rise = frame_strobe & bit_in & ~level;

endmodule // frame_bit_edge

// [hdl/pp_handshake_pkg.sv]
/*
  Constants shared by the profile position set-point handshake: control and
  status word bit positions, command patterns, status word images and mode code.
  Assumes a 16-bit cyclic control word and status word and one clock domain.

*/
package pp_handshake_pkg;

  // control word bit positions
  localparam int CW_SWITCH_ON  = 0;
  localparam int CW_EN_VOLTAGE = 1;
  localparam int CW_QUICK_STOP = 2;
  localparam int CW_ENABLE_OP  = 3;
  localparam int CW_NEW_SETPT  = 4;
  localparam int CW_IMMEDIATE  = 5;
  localparam int CW_RELATIVE   = 6;
  localparam int CW_HALT       = 8;
  localparam int CW_BUFFERED   = 9;

  // status word bit positions
  localparam int SW_REACHED    = 10;
  localparam int SW_ACK        = 12;
  localparam int SW_FOLLOW_ERR = 13;

  // low nibble command patterns
  localparam logic [2:0] CMD_SHUTDOWN  = 3'h6;
  localparam logic [3:0] CMD_SWITCH_ON = 4'h7;
  localparam logic [3:0] CMD_ENABLE_OP = 4'hf;

  // status word images per enable state
  localparam logic [15:0] STAT_DISABLED = 16'h0050;
  localparam logic [15:0] STAT_READY    = 16'h0031;
  localparam logic [15:0] STAT_SWITCHED = 16'h0033;
  localparam logic [15:0] STAT_OP_BASE  = 16'h0037;
  localparam logic [7:0]  STAT_OP_LOW   = 8'h37;

  // mode selector code for profile position, and mode display value at reset
  localparam logic [15:0] MODE_PROFILE_POS = 16'h0001;
  localparam logic [15:0] MODE_RESET       = 16'h0000;

  // enable sequence states
  typedef enum logic [1:0] {
    ST_DISABLED,
    ST_READY,
    ST_SWITCHED,
    ST_OP
  } enable_state_t;

endpackage

// [hdl/pp_setpoint_handshake.sv]
/*
  Decodes the cyclic control word in profile position mode, keeps the enable
  state, runs the new set-point / acknowledge handshake with one buffered slot,
  and hands targets to the motion profile generator; builds the status word.
  Assumes control words arrive on mclk with a one-cycle pd_update strobe, and
  that the generator drops axis_at_target the cycle after it sees setpoint_load.
  Limitation: one buffered target; further plain edges while it is full are lost.
*/
`timescale 1ns/1ns
module pp_setpoint_handshake #(
  parameter int POS_W = 32
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              pd_update,
  input  wire logic [15:0]       control_word,
  input  wire logic [15:0]       mode_selector_slot,
  input  wire logic [POS_W-1:0]  target_position_slot,
  input  wire logic [POS_W-1:0]  current_position,
  input  wire logic              axis_at_target,
  input  wire logic              axis_speed_zero,
  input  wire logic              following_error,
  output logic [15:0]            status_word,
  output logic [15:0]            mode_display,
  output logic [POS_W-1:0]       setpoint_target,
  output logic                   setpoint_load,
  output logic                   setpoint_blend,
  output logic                   setpoint_immediate,
  output logic                   halt_request,
  output logic                   motion_enable
);

  // position width must hold a 16-bit slot at least
  if (POS_W < 16 || POS_W > 64) begin : g_width_check
    $error("pp_setpoint_handshake: POS_W out of range");
  end

  pp_handshake_pkg::enable_state_t state;
  pp_handshake_pkg::enable_state_t next_state;

  // handshake and buffer bookkeeping
  logic             ack;
  logic             busy;
  logic             pending;
  logic [POS_W-1:0] pend_target;
  logic             pend_blend;
  logic             nsp_level;
  logic             nsp_rise;

  // previous-word comparison of the new set-point bit
  frame_bit_edge u_nsp_edge (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .frame_strobe (pd_update),
    .bit_in       (control_word[pp_handshake_pkg::CW_NEW_SETPT]),
    .level        (nsp_level),
    .rise         (nsp_rise)
  );

  // command decode of the low nibble
  wire cmd_disable   = ~(control_word[pp_handshake_pkg::CW_EN_VOLTAGE]
                         & control_word[pp_handshake_pkg::CW_QUICK_STOP]);
  wire cmd_shutdown  = control_word[2:0] == pp_handshake_pkg::CMD_SHUTDOWN;
  wire cmd_switch_on = control_word[3:0] == pp_handshake_pkg::CMD_SWITCH_ON;
  wire cmd_enable_op = control_word[3:0] == pp_handshake_pkg::CMD_ENABLE_OP;

  // enable state transitions, taken only on a received frame
  always_comb begin
    next_state = state;
    if (pd_update) begin
      unique case (state)
        pp_handshake_pkg::ST_DISABLED: begin
          if (cmd_shutdown) begin
            next_state = pp_handshake_pkg::ST_READY;
          end
        end
        pp_handshake_pkg::ST_READY: begin
          if (cmd_disable) begin
            next_state = pp_handshake_pkg::ST_DISABLED;
          end else if (cmd_switch_on) begin
            next_state = pp_handshake_pkg::ST_SWITCHED;
          end else if (cmd_enable_op) begin
            next_state = pp_handshake_pkg::ST_OP; // 0x0007 step may be skipped
          end
        end
        pp_handshake_pkg::ST_SWITCHED, pp_handshake_pkg::ST_OP: begin
          if (cmd_disable) begin
            next_state = pp_handshake_pkg::ST_DISABLED;
          end else if (cmd_shutdown) begin
            next_state = pp_handshake_pkg::ST_READY;
          end else if (cmd_switch_on) begin
            next_state = pp_handshake_pkg::ST_SWITCHED;
          end else if (cmd_enable_op) begin
            next_state = pp_handshake_pkg::ST_OP;
          end
        end
      endcase
    end
  end

  // enable state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= pp_handshake_pkg::ST_DISABLED;
    end else begin
      state <= next_state;
    end
  end

  // mode, run and halt are latched per frame; control word need not be held
  wire frame_op   = pd_update && next_state == pp_handshake_pkg::ST_OP;
  wire frame_pp   = frame_op && mode_selector_slot == pp_handshake_pkg::MODE_PROFILE_POS;
  wire frame_halt = frame_op && control_word[pp_handshake_pkg::CW_HALT];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_display  <= pp_handshake_pkg::MODE_RESET;
      motion_enable <= 1'b0;
      halt_request  <= 1'b0;
    end else if (pd_update) begin
      mode_display  <= mode_selector_slot;
      motion_enable <= frame_pp;
      halt_request  <= frame_halt;
    end
  end

  // set-point decode: a fresh edge is taken only when the last one was released
  wire imm_bit  = control_word[pp_handshake_pkg::CW_IMMEDIATE];
  wire buf_bit  = control_word[pp_handshake_pkg::CW_BUFFERED];
  wire rel_bit  = control_word[pp_handshake_pkg::CW_RELATIVE];
  wire accept   = frame_pp && nsp_rise && !ack;
  wire [POS_W-1:0] abs_target = rel_bit ? POS_W'(current_position + target_position_slot)
                                        : target_position_slot;

  // frame-level clears; leaving the mode must also block a queued release
  wire leave_pp     = pd_update && !frame_pp;
  wire nsp_cleared  = pd_update && !control_word[pp_handshake_pkg::CW_NEW_SETPT];

  // immediate overrides everything; otherwise an idle axis starts directly
  wire load_direct = accept && (imm_bit || (!busy && !pending));
  wire store_pend  = accept && !imm_bit && busy && !pending;
  // buffered slot waits for the running target, and for halt to lift
  wire release_pend = pending && motion_enable && !halt_request && !load_direct && !leave_pp
                      && (!busy || (axis_at_target && !setpoint_load));
  wire next_load    = load_direct || release_pend;

  // hand-over to the profile generator, one-cycle load pulse
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      setpoint_load      <= 1'b0;
      setpoint_blend     <= 1'b0;
      setpoint_immediate <= 1'b0;
      setpoint_target    <= '0;
    end else begin
      setpoint_load      <= next_load;
      setpoint_blend     <= release_pend && pend_blend;
      setpoint_immediate <= load_direct && imm_bit;
      if (next_load) begin
        setpoint_target <= load_direct ? abs_target : pend_target;
      end
    end
  end

  // one buffered target, stored as absolute so a later move cannot shift it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pending     <= 1'b0;
      pend_blend  <= 1'b0;
      pend_target <= '0;
    end else if (store_pend) begin
      pending     <= 1'b1;
      pend_blend  <= buf_bit;
      pend_target <= abs_target;
    end else if (release_pend || leave_pp || (accept && imm_bit)) begin
      pending     <= 1'b0;
    end
  end

  // positioning in progress; load wins over the at-target clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else if (next_load) begin
      busy <= 1'b1;
    end else if (leave_pp || (axis_at_target && !setpoint_load)) begin
      busy <= 1'b0;
    end
  end

  // acknowledge: setting on a load beats the clear in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else if (next_load) begin
      ack <= 1'b1;
    end else if (nsp_cleared || leave_pp) begin
      ack <= 1'b0;
    end
  end

  // mode-specific status bits; reached means zero speed while halted
  wire reached = halt_request ? axis_speed_zero
                              : (!busy && !pending && axis_at_target);
  logic [15:0] next_status;

  always_comb begin
    next_status = pp_handshake_pkg::STAT_DISABLED;
    unique case (state)
      pp_handshake_pkg::ST_DISABLED: next_status = pp_handshake_pkg::STAT_DISABLED;
      pp_handshake_pkg::ST_READY:    next_status = pp_handshake_pkg::STAT_READY;
      pp_handshake_pkg::ST_SWITCHED: next_status = pp_handshake_pkg::STAT_SWITCHED;
      pp_handshake_pkg::ST_OP: begin
        next_status = pp_handshake_pkg::STAT_OP_BASE;
        next_status[pp_handshake_pkg::SW_REACHED]    = motion_enable && reached;
        next_status[pp_handshake_pkg::SW_ACK]        = ack;
        next_status[pp_handshake_pkg::SW_FOLLOW_ERR] = following_error;
      end
    endcase
  end

  // status word registered; state images match the enable sequence
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_word <= pp_handshake_pkg::STAT_DISABLED;
    end else begin
      status_word <= next_status;
    end
  end

  // checks on the handshake and the status word
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  immediate_start_a: assert property (accept && imm_bit |=>
      setpoint_load && setpoint_immediate && !setpoint_blend)
    else $error("immediate set-point not loaded next cycle");

  wait_target_a: assert property (setpoint_load && !setpoint_immediate
      |-> $past(!busy || axis_at_target))
    else $error("queued set-point loaded while still positioning");

  blend_chain_a: assert property (setpoint_blend |-> setpoint_load
      && !setpoint_immediate && $past(pending))
    else $error("blended load without a buffered target");

  relative_sum_a: assert property (accept && imm_bit && rel_bit |=>
      setpoint_target == POS_W'($past(current_position) + $past(target_position_slot)))
    else $error("relative target not added to current position");

  halt_stays_a: assert property (frame_op && control_word[pp_handshake_pkg::CW_HALT]
      |=> halt_request ##1 status_word[7:0] == pp_handshake_pkg::STAT_OP_LOW)
    else $error("halt left operation enabled");

  reached_halt_a: assert property (state == pp_handshake_pkg::ST_OP && halt_request
      && motion_enable |=> status_word[pp_handshake_pkg::SW_REACHED]
      == $past(axis_speed_zero))
    else $error("target reached wrong while halted");

  ack_follows_a: assert property (setpoint_load |-> ##1
      (status_word[pp_handshake_pkg::SW_ACK] || $past(leave_pp)))
    else $error("acknowledge not shown after load");

  ack_release_a: assert property (ack && nsp_cleared && !next_load |=>
      !ack ##1 !status_word[pp_handshake_pkg::SW_ACK])
    else $error("acknowledge not cleared after new set-point dropped");

  stop_on_seven_a: assert property (pd_update && state == pp_handshake_pkg::ST_OP
      && cmd_switch_on |=> !motion_enable ##1
      status_word == pp_handshake_pkg::STAT_SWITCHED)
    else $error("falling back to switched on did not stop");

  ready_image_a: assert property (pd_update && state == pp_handshake_pkg::ST_DISABLED
      && cmd_shutdown |=> ##1 status_word == pp_handshake_pkg::STAT_READY)
    else $error("ready status image wrong");

  halt_holds_pend_a: assert property (pending && halt_request |=>
      !setpoint_load || setpoint_immediate)
    else $error("buffered set-point released while halted");

  leave_clears_a: assert property (leave_pp |=>
      !busy && !pending && !ack && !setpoint_load && !motion_enable)
    else $error("leaving profile position left work behind");

  absolute_target_a: assert property (load_direct && !rel_bit |=>
      setpoint_target == $past(target_position_slot))
    else $error("absolute target not passed through");

  reached_run_a: assert property (state == pp_handshake_pkg::ST_OP && !halt_request
      && busy |=> !status_word[pp_handshake_pkg::SW_REACHED])
    else $error("target reached shown while positioning");

  edge_prev_a: assert property (pd_update |=>
      nsp_level == $past(control_word[pp_handshake_pkg::CW_NEW_SETPT]))
    else $error("previous new set-point level not kept");

  cover_immediate: cover property (setpoint_load && setpoint_immediate && $past(busy));
  cover_blend:     cover property (setpoint_load && setpoint_blend);
  cover_halt:      cover property (halt_request && status_word[pp_handshake_pkg::SW_REACHED]);
  cover_handshake: cover property (ack ##[1:50] !ack);
  cover_relative:  cover property (accept && rel_bit);

endmodule // pp_setpoint_handshake

// [test/motion_gen_model.sv]
/*
  Behavioural motion profile generator facing the set-point handshake.
  Assumes setpoint_load pulses for one mclk cycle; slow picks a long move.
*/
`timescale 1ns/1ns
module motion_gen_model #(
  parameter int POS_W = 32
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             slow,
  input  wire logic             setpoint_load,
  input  wire logic [POS_W-1:0] setpoint_target,
  input  wire logic             halt_request,
  output logic                  axis_at_target,
  output logic                  axis_speed_zero,
  output logic [POS_W-1:0]      current_position
);
  logic [7:0]       move_left;
  logic [1:0]       halt_cnt;
  logic [POS_W-1:0] goal;

  // at rest when parked on the goal or after a three cycle halt ramp
  assign axis_speed_zero = axis_at_target | (halt_cnt == 2'h3);

  // move countdown; halt freezes it so the axis stops short of the goal
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      axis_at_target   <= 1'b1;
      move_left        <= 8'h00;
      goal             <= '0;
      current_position <= '0;
    end else if (setpoint_load) begin
      axis_at_target <= 1'b0;
      move_left      <= slow ? 8'h1e : 8'h03;
      goal           <= setpoint_target;
    end else if (!axis_at_target && !halt_request) begin
      move_left <= move_left - 8'h01;
      if (move_left == 8'h01) begin
        axis_at_target   <= 1'b1;
        current_position <= goal;
      end
    end
  end

  // halt dwell, saturating so speed zero stays while halted
  always_ff @(posedge mclk) begin
    if (sys_rst || !halt_request) halt_cnt <= 2'h0;
    else if (halt_cnt != 2'h3) halt_cnt <= halt_cnt + 2'h1;
  end
endmodule // motion_gen_model

// [test/pp_setpoint_handshake_bench.sv]
/*
  Self-checking bench for the set-point handshake: sends control word frames
  and checks status word and generator commands. Assumes the generator model.
*/
`timescale 1ns/1ns
module pp_setpoint_handshake_bench;
  logic        mclk, sys_rst, pd_update, slow, following_error;
  logic [15:0] control_word, mode_selector_slot, status_word, mode_display;
  logic [31:0] target_position_slot, current_position, setpoint_target, ld_target;
  logic        axis_at_target, axis_speed_zero, setpoint_load, setpoint_blend;
  logic        setpoint_immediate, halt_request, motion_enable, seen, ld_blend, ld_imm;
  int          errors, compares, cycles;
  logic [15:0] seq_cw [3] = '{16'h0000, 16'h0006, 16'h0007};
  logic [15:0] seq_st [3] = '{16'h0050, 16'h0031, 16'h0033};
  logic [15:0] chain_cw [2] = '{16'h001f, 16'h021f};

  pp_setpoint_handshake u_dut (.mclk(mclk), .sys_rst(sys_rst), .pd_update(pd_update),
    .control_word(control_word), .mode_selector_slot(mode_selector_slot),
    .target_position_slot(target_position_slot), .current_position(current_position),
    .axis_at_target(axis_at_target), .axis_speed_zero(axis_speed_zero),
    .following_error(following_error), .status_word(status_word),
    .mode_display(mode_display), .setpoint_target(setpoint_target),
    .setpoint_load(setpoint_load), .setpoint_blend(setpoint_blend),
    .setpoint_immediate(setpoint_immediate), .halt_request(halt_request),
    .motion_enable(motion_enable));

  motion_gen_model u_gen (.mclk(mclk), .sys_rst(sys_rst), .slow(slow),
    .setpoint_load(setpoint_load), .setpoint_target(setpoint_target),
    .halt_request(halt_request), .axis_at_target(axis_at_target),
    .axis_speed_zero(axis_speed_zero), .current_position(current_position));

  // clock and hang guard; whole run is a few hundred cycles
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one frame: inputs change at the falling edge, held one full cycle
  task automatic send(input logic [15:0] cw, input logic [31:0] tgt);
    control_word         = cw;
    target_position_slot = tgt;
    pd_update            = 1'b1;
    @(negedge mclk);
    pd_update = 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask

  // load is a one-cycle pulse, so it is caught in the cycle it stands
  task automatic wait_load(input int max);
    seen = 1'b0;
    for (int i = 0; i < max && !seen; i++) begin
      if (setpoint_load === 1'b1) begin
        seen      = 1'b1;
        ld_target = setpoint_target;
        ld_blend  = setpoint_blend;
        ld_imm    = setpoint_immediate;
      end else @(negedge mclk);
    end
    @(negedge mclk); // next frame must not share this time step
  endtask

  // status lags a frame by two cycles and a load by one, so skip two before polling
  task automatic wait_reached();
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 50 && status_word[10] !== 1'b1; i++) @(negedge mclk);
  endtask

  task automatic wrap_up();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    {pd_update, slow, following_error} = 3'h0;
    control_word         = 16'h0000;
    mode_selector_slot   = 16'h0001;
    target_position_slot = 32'h0;
    sys_rst              = 1'b1;
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    check(status_word, 16'h0050);
    check(mode_display, 16'h0000);
    // enable sequence, one status image per step
    for (int i = 0; i < 3; i++) begin
      send(seq_cw[i], 32'h0);
      settle();
      check(status_word, seq_st[i]);
    end
    send(16'h000f, 32'h0);
    settle();
    check(status_word[7:0], 8'h37);
    check(motion_enable, 1'b1);
    check(mode_display, 16'h0001);
    // absolute move and full handshake
    send(16'h001f, 32'h100);
    wait_load(4);
    check(seen, 1'b1);
    check(ld_target, 32'h100);
    settle();
    check(status_word[12], 1'b1);
    check(status_word[10], 1'b0);
    wait_reached();
    check(status_word[10], 1'b1);
    send(16'h000f, 32'h0);
    settle();
    check(status_word[12], 1'b0);
    // relative target against the reached position
    send(16'h005f, 32'h10);
    wait_load(4);
    check(ld_target, 32'h110);
    wait_reached();
    check(status_word[10], 1'b1);
    send(16'h000f, 32'h0);
    settle();
    // second edge while busy: plain waits, buffered chains
    slow = 1'b1;
    for (int i = 0; i < 2; i++) begin
      send(16'h001f, 32'h200 + i);
      wait_load(4);
      send(16'h000f, 32'h0);
      settle();
      send(chain_cw[i], 32'h400 + i);
      wait_load(6);
      check(seen, 1'b0);
      wait_load(60);
      check(seen, 1'b1);
      check(ld_target, 32'h400 + i);
      check(ld_blend, i[0]);
      wait_reached();
      send(16'h000f, 32'h0);
      settle();
    end
    // immediate change while a slow move runs
    send(16'h001f, 32'h600);
    wait_load(4);
    send(16'h000f, 32'h0);
    settle();
    send(16'h003f, 32'h700);
    wait_load(3);
    check(seen, 1'b1);
    check(ld_imm, 1'b1);
    check(ld_target, 32'h700);
    send(16'h000f, 32'h0);
    settle();
    // halt mid-move: stays enabled, bit 10 follows zero speed
    send(16'h010f, 32'h0);
    settle();
    check(halt_request, 1'b1);
    check(status_word[7:0], 8'h37);
    check(status_word[10], 1'b0);
    repeat (4) @(negedge mclk);
    check(status_word[10], 1'b1);
    send(16'h000f, 32'h0);
    wait_reached();
    check(status_word[10], 1'b1);
    // following error copied into the enabled status image
    following_error = 1'b1;
    settle();
    check(status_word[13], 1'b1);
    following_error = 1'b0;
    // back to switched on: mode stops, edges refused
    send(16'h0007, 32'h0);
    settle();
    check(motion_enable, 1'b0);
    check(status_word, 16'h0033);
    send(16'h0017, 32'h900);
    wait_load(4);
    check(seen, 1'b0);
    // other mode chosen while switched on: enabled, but no positioning
    mode_selector_slot = 16'h0003;
    send(16'h000f, 32'h0);
    settle();
    check(mode_display, 16'h0003);
    check(motion_enable, 1'b0);
    check(status_word, 16'h0037);
    send(16'h001f, 32'ha00);
    wait_load(4);
    check(seen, 1'b0);
    wrap_up();
  end
endmodule // pp_setpoint_handshake_bench
